// >>> design/option_cfg_pkg.sv
// Package of constants for the fixed option configuration block
package option_cfg_pkg;
	// Option word layout, eleven bits in all
	localparam int OPTION_BITS = 11;
	localparam int KEYSCAN_LINES = 8;
	localparam int OPT_KEYSCAN_LSB = 0;
	localparam int OPT_WATCHDOG_POS = 8;
	localparam int OPT_STOP_POS = 9;
	localparam int OPT_LEVEL_POS = 10;

	// Default option values built into the part
	localparam logic [7:0] DEF_KEYSCAN_ENABLE = 8'hFF;
	localparam logic DEF_WATCHDOG_ENABLE = 1'h1;
	localparam logic DEF_STOP_ENABLE = 1'h1;
	localparam logic DEF_LEVEL_SENSE = 1'h0;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_OPTIONS = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;

	// Status and mask bit positions
	localparam int STATUS_W = 5;
	localparam int ST_EXT_INT = 0;
	localparam int ST_KEYSCAN = 1;
	localparam int ST_WATCHDOG = 2;
	localparam int ST_STOP = 3;
	localparam int ST_WAIT = 4;
	localparam logic [4:0] MASK_RESET = 5'h00;

	// State register layout
	localparam int STATE_LATCH_POS = 0;
	localparam int STATE_EXT_POS = 1;
	localparam int STATE_KEY_LSB = 2;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Watchdog timeout and the clock rate it is counted in
	localparam int CLK_MHZ = 100;
	localparam int WATCHDOG_TIMEOUT_US = 1000;
	localparam int WATCHDOG_CYCLES = WATCHDOG_TIMEOUT_US * CLK_MHZ;
endpackage

// >>> design/pin_fall_sync.sv
// Two-flop synchroniser with falling edge detection for a group of pins
module pin_fall_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Asynchronous pins
	input wire logic [WIDTH-1:0] pin,
	// Synchronised level and falling edge pulse
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fall
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} sync_t;

	sync_t state;
	sync_t next_state;

	generate
		if (WIDTH < 1)
		begin : g_check
			$error("pin_fall_sync needs at least one pin");
		end
	endgenerate

	// Shift chain; first flop feeds only the second
	always_comb
	begin
		next_state = state;
		next_state.meta = pin;
		next_state.sync = state.meta;
		next_state.prev = state.sync;
	end

	// Idle pins are pulled high, so reset to ones
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			state <= '1;
		else
			state <= next_state;
	end

	assign level = state.sync;
	assign fall = state.prev & ~state.sync;
endmodule // pin_fall_sync

// >>> design/option_cfg.sv
// Fixed option configuration with interrupt, stop and watchdog gating
// Summary of operation
// R01: Eleven fixed option bits: eight keyscan, sensitivity, watchdog, stop.
// R02: Option bits are constants; no software path can change them.
// R03: Each keyscan option bit enables that line's pull-up and interrupt.
// R04: Watchdog runs and resets only when its option bit is one.
// R05: Stop option one: stop instruction enters true stop mode.
// R06: Stop option zero: stop instruction behaves exactly as wait.
// R07: Sensitivity one: interrupt on falling edge and while pin low.
// R08: Sensitivity zero: interrupt on falling edge only.
// R09: Keyscan interrupt uses the same sensitivity as the interrupt pin.
// R10: Qualifying low sets request latch; taken at instruction end if unmasked.
// R11: Level mode re-sets the latch while pin or enabled keyscan stays low.
module option_cfg #(
	parameter logic [7:0] KEYSCAN_ENABLE = option_cfg_pkg::DEF_KEYSCAN_ENABLE,
	parameter logic WATCHDOG_ENABLE = option_cfg_pkg::DEF_WATCHDOG_ENABLE,
	parameter logic STOP_ENABLE = option_cfg_pkg::DEF_STOP_ENABLE,
	parameter logic LEVEL_SENSE = option_cfg_pkg::DEF_LEVEL_SENSE,
	parameter int unsigned WATCHDOG_CYCLES = option_cfg_pkg::WATCHDOG_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic [option_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [option_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic ext_int_n,
	input wire logic [7:0] keyscan_pin,
	// Fixed option levels to port, timer and core
	output logic [7:0] keyscan_pull_enable,
	output logic watchdog_option_enable,
	output logic stop_instruction_option_enable,
	output logic level_sense_option,
	// Core handshake
	input wire logic instr_end,
	input wire logic int_mask_bit,
	input wire logic stop_decoded,
	input wire logic wait_decoded,
	input wire logic watchdog_service,
	output logic interrupt_start,
	output logic enter_stop,
	output logic enter_wait,
	output logic watchdog_reset,
	// Interrupt to system
	output logic interrupt
);
	localparam int SW = option_cfg_pkg::STATUS_W;

	typedef struct packed {
		logic aw_held;
		logic [option_cfg_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic req_latch;
		logic [SW-1:0] status;
		logic [SW-1:0] mask;
		logic irq_out;
		logic [31:0] wdog_count;
		logic wdog_reset;
		logic go_stop;
		logic go_wait;
		logic int_start;
	} state_t;

	state_t state;
	state_t next_state;

	// Option word, fixed at elaboration
	logic [option_cfg_pkg::OPTION_BITS-1:0] options; // [R01]
	logic ext_level;
	logic ext_fall;
	logic [7:0] key_level;
	logic [7:0] key_fall;
	logic edge_hit;
	logic level_hit;
	logic set_latch;
	logic take_int;
	logic [SW-1:0] events;
	logic [31:0] wr_mask;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	generate
		if (WATCHDOG_CYCLES < 2)
		begin : g_check
			$error("option_cfg watchdog timeout must be at least two cycles");
		end
	endgenerate

	// Option constants; no register drives them
	assign options[option_cfg_pkg::OPT_KEYSCAN_LSB +: 8] = KEYSCAN_ENABLE; // [R01] [R02]
	assign options[option_cfg_pkg::OPT_WATCHDOG_POS] = WATCHDOG_ENABLE; // [R01] [R02]
	assign options[option_cfg_pkg::OPT_STOP_POS] = STOP_ENABLE; // [R01] [R02]
	assign options[option_cfg_pkg::OPT_LEVEL_POS] = LEVEL_SENSE; // [R01] [R02]

	// Option levels seen by the rest of the chip
	assign keyscan_pull_enable = KEYSCAN_ENABLE; // [R03]
	assign watchdog_option_enable = WATCHDOG_ENABLE; // [R04]
	assign stop_instruction_option_enable = STOP_ENABLE;
	assign level_sense_option = LEVEL_SENSE;

	// Interrupt pin synchroniser
	pin_fall_sync #(
		.WIDTH(1)
	) u_ext_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin(ext_int_n),
		.level(ext_level),
		.fall(ext_fall)
	);

	// Keyscan line synchroniser
	pin_fall_sync #(
		.WIDTH(8)
	) u_key_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin(keyscan_pin),
		.level(key_level),
		.fall(key_fall)
	);

	// Request qualification; disabled keyscan lines never count
	always_comb
	begin
		edge_hit = ext_fall | (|(key_fall & KEYSCAN_ENABLE)); // [R03] [R07] [R08] [R09]
		level_hit = LEVEL_SENSE & (~ext_level | (|(~key_level & KEYSCAN_ENABLE))); // [R07] [R09] [R11]
		set_latch = edge_hit | level_hit; // [R08] [R10]
		take_int = instr_end & state.req_latch & ~int_mask_bit; // [R10]
	end

	// Write strobe expansion
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			wr_mask[i*8 +: 8] = {8{state.w_strb[i]}};
		end
	end

	// Read decode
	always_comb
	begin
		rd_word = '0;
		rd_resp = option_cfg_pkg::RESP_OKAY;
		unique case (s_axi_araddr)
			option_cfg_pkg::OFS_OPTIONS:
			begin
				rd_word[option_cfg_pkg::OPTION_BITS-1:0] = options; // [R01]
			end
			option_cfg_pkg::OFS_STATUS:
			begin
				rd_word[SW-1:0] = state.status;
			end
			option_cfg_pkg::OFS_MASK:
			begin
				rd_word[SW-1:0] = state.mask;
			end
			option_cfg_pkg::OFS_STATE:
			begin
				rd_word[option_cfg_pkg::STATE_LATCH_POS] = state.req_latch;
				rd_word[option_cfg_pkg::STATE_EXT_POS] = ext_level;
				rd_word[option_cfg_pkg::STATE_KEY_LSB +: 8] = key_level;
			end
			default:
			begin
				rd_resp = option_cfg_pkg::RESP_SLVERR;
			end
		endcase
	end

	// Next state of the whole block
	always_comb
	begin
		next_state = state;
		events = '0;

		// Accept address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (state.b_valid && s_axi_bready)
		begin
			next_state.b_valid = 1'b0;
		end

		// Interrupt request latch; set wins over the clear
		next_state.req_latch = (state.req_latch & ~take_int) | set_latch; // [R10] [R11]
		next_state.int_start = take_int; // [R10]

		// Stop decoding depends on the option
		next_state.go_stop = stop_decoded & STOP_ENABLE; // [R05]
		next_state.go_wait = wait_decoded | (stop_decoded & ~STOP_ENABLE); // [R06]

		// Watchdog counts only when fitted
		next_state.wdog_reset = 1'b0;
		if (!WATCHDOG_ENABLE || watchdog_service)
		begin
			next_state.wdog_count = '0; // [R04]
		end
		else if (state.wdog_count == 32'(WATCHDOG_CYCLES - 1))
		begin
			next_state.wdog_count = '0;
			next_state.wdog_reset = 1'b1; // [R04]
		end
		else
		begin
			next_state.wdog_count = state.wdog_count + 32'h1;
		end

		// Events for the sticky status bits
		events[option_cfg_pkg::ST_EXT_INT] = ext_fall | (LEVEL_SENSE & ~ext_level);
		events[option_cfg_pkg::ST_KEYSCAN] = edge_hit & ~ext_fall | level_hit & ext_level;
		events[option_cfg_pkg::ST_WATCHDOG] = next_state.wdog_reset;
		events[option_cfg_pkg::ST_STOP] = next_state.go_stop;
		events[option_cfg_pkg::ST_WAIT] = next_state.go_wait;

		// Register write once both halves are held
		if (state.aw_held && state.w_held && !state.b_valid)
		begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.b_valid = 1'b1;
			next_state.b_resp = option_cfg_pkg::RESP_OKAY;
			unique case (state.aw_addr)
				option_cfg_pkg::OFS_STATUS:
				begin
					next_state.status = state.status & ~(state.w_data[SW-1:0] & wr_mask[SW-1:0]);
				end
				option_cfg_pkg::OFS_MASK:
				begin
					next_state.mask = (state.mask & ~wr_mask[SW-1:0]) | (state.w_data[SW-1:0] & wr_mask[SW-1:0]);
				end
				option_cfg_pkg::OFS_STATE:
				begin
					next_state.b_resp = option_cfg_pkg::RESP_SLVERR;
				end
				option_cfg_pkg::OFS_OPTIONS:
				begin
					next_state.b_resp = option_cfg_pkg::RESP_SLVERR; // [R02]
				end
				default:
				begin
					next_state.b_resp = option_cfg_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Sticky set after any clear so the event wins
		next_state.status = next_state.status | events;

		// Read channel
		if (state.r_valid && s_axi_rready)
		begin
			next_state.r_valid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_state.r_valid = 1'b1;
			next_state.r_data = rd_word;
			next_state.r_resp = rd_resp;
		end

		// Level interrupt from unmasked status
		next_state.irq_out = |(next_state.status & next_state.mask);
	end

	// State register
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= '0;
			state.mask <= option_cfg_pkg::MASK_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Bus handshakes
	assign s_axi_awready = ~state.aw_held & ~state.b_valid;
	assign s_axi_wready = ~state.w_held & ~state.b_valid;
	assign s_axi_arready = ~state.r_valid;
	assign s_axi_bvalid = state.b_valid;
	assign s_axi_bresp = state.b_resp;
	assign s_axi_rvalid = state.r_valid;
	assign s_axi_rdata = state.r_data;
	assign s_axi_rresp = state.r_resp;

	// Core and system outputs
	assign interrupt_start = state.int_start;
	assign enter_stop = state.go_stop;
	assign enter_wait = state.go_wait;
	assign watchdog_reset = state.wdog_reset;
	assign interrupt = state.irq_out;
endmodule // option_cfg

// >>> test/option_cfg_checker.sv
// Checker of option levels and core handshake timing
module option_cfg_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pin and option levels
	input wire logic ext_int_n,
	input wire logic [7:0] keyscan_pull_enable,
	input wire logic watchdog_option_enable,
	input wire logic stop_instruction_option_enable,
	input wire logic level_sense_option,
	// Core handshake
	input wire logic instr_end,
	input wire logic int_mask_bit,
	input wire logic stop_decoded,
	input wire logic wait_decoded,
	input wire logic interrupt_start,
	input wire logic enter_stop,
	input wire logic enter_wait,
	input wire logic watchdog_reset
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Option levels and their effects
	AST_OPT_CONST: assert property (1'b1 |=> $stable({keyscan_pull_enable, watchdog_option_enable,
		stop_instruction_option_enable, level_sense_option})) else $error("option level moved");
	AST_STOP_KIND: assert property (stop_decoded |=> enter_stop == stop_instruction_option_enable
		&& enter_wait != stop_instruction_option_enable) else $error("stop entered wrong mode");
	AST_WAIT_ENTRY: assert property (wait_decoded |=> enter_wait && !enter_stop) else $error("wait not entered");
	AST_WDG_GATED: assert property (watchdog_reset |-> watchdog_option_enable) else $error("watchdog off but fired");
	AST_WDG_GAP: assert property (watchdog_reset |=> !watchdog_reset [*8]) else $error("watchdog fired too soon");
	// Interrupt request handling
	AST_INT_CAUSE: assert property (interrupt_start |-> $past(instr_end) && !$past(int_mask_bit))
		else $error("interrupt started without cause");
	AST_INT_MASKED: assert property (instr_end && int_mask_bit |=> !interrupt_start) else $error("masked start");
	AST_LEVEL_REQ: assert property (level_sense_option && !ext_int_n [*6] ##0 (instr_end && !int_mask_bit)
		|=> interrupt_start) else $error("held low level not taken");
	// Main scenarios
	COV_START: cover property (interrupt_start);
	COV_WAIT: cover property (stop_decoded ##1 enter_wait);
	COV_STOP: cover property (stop_decoded ##1 enter_stop);
	COV_WDG: cover property (watchdog_reset);
endmodule // option_cfg_checker

bind option_cfg option_cfg_checker chk_u (.clk_sys(clk_sys), .nrst(nrst), .ext_int_n(ext_int_n),
	.keyscan_pull_enable(keyscan_pull_enable), .watchdog_option_enable(watchdog_option_enable),
	.stop_instruction_option_enable(stop_instruction_option_enable), .level_sense_option(level_sense_option),
	.instr_end(instr_end), .int_mask_bit(int_mask_bit), .stop_decoded(stop_decoded), .wait_decoded(wait_decoded),
	.interrupt_start(interrupt_start), .enter_stop(enter_stop), .enter_wait(enter_wait),
	.watchdog_reset(watchdog_reset));

// >>> test/test_option_cfg.sv
// Testbench of the option configuration block
module test_option_cfg;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WDG = 16;
	logic clk_sys, nrst, aw_v, w_v, b_r, ar_v, r_r, ext_int_n, instr_end, int_mask_bit, stop_decoded, wait_decoded;
	logic wd_s, svc;
	logic [7:0] aw_a, ar_a, keyscan_pin;
	logic [31:0] w_d, rdv;
	logic [1:0] rsp;
	logic [2:0] o, o2;
	logic wd2_hit = 1'b0;
	wire logic awr, wrd, bv, arr, rv, wdo, sto, lvo, ist, est, ewt, wrst, irq;
	wire logic [1:0] br, rr;
	wire logic [7:0] kpe;
	wire logic wdo2, sto2, lvo2, ist2, est2, ewt2, wrst2;
	wire logic [7:0] kpe2;
	wire logic [31:0] rdd;
	int err_count, compares, k, i;

	// Block under test with short watchdog, four keyscan lines, stop as wait, level sensing
	option_cfg #(.KEYSCAN_ENABLE(8'h0F), .WATCHDOG_ENABLE(1'b1), .STOP_ENABLE(1'b0), .LEVEL_SENSE(1'b1),
		.WATCHDOG_CYCLES(WDG)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
		.s_axi_awready(awr), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r_r),
		.ext_int_n(ext_int_n), .keyscan_pin(keyscan_pin), .keyscan_pull_enable(kpe), .watchdog_option_enable(wdo),
		.stop_instruction_option_enable(sto), .level_sense_option(lvo), .instr_end(instr_end),
		.int_mask_bit(int_mask_bit), .stop_decoded(stop_decoded), .wait_decoded(wait_decoded),
		.watchdog_service(wd_s), .interrupt_start(ist), .enter_stop(est), .enter_wait(ewt), .watchdog_reset(wrst),
		.interrupt(irq));

	// Second build: upper keyscan lines, no watchdog, true stop, edge only; bus answers unused
	option_cfg #(.KEYSCAN_ENABLE(8'hF0), .WATCHDOG_ENABLE(1'b0), .STOP_ENABLE(1'b1), .LEVEL_SENSE(1'b0),
		.WATCHDOG_CYCLES(WDG)) alt_u (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
		.s_axi_awready(), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(r_r),
		.ext_int_n(ext_int_n), .keyscan_pin(keyscan_pin), .keyscan_pull_enable(kpe2), .watchdog_option_enable(wdo2),
		.stop_instruction_option_enable(sto2), .level_sense_option(lvo2), .instr_end(instr_end),
		.int_mask_bit(int_mask_bit), .stop_decoded(stop_decoded), .wait_decoded(wait_decoded),
		.watchdog_service(wd_s), .interrupt_start(ist2), .enter_stop(est2), .enter_wait(ewt2),
		.watchdog_reset(wrst2), .interrupt());

	// Clock of 10 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Watchdog service follows its enable
	always @(posedge clk_sys) wd_s <= svc;

	// Sticky record of any timeout from the build without watchdog
	always @(posedge clk_sys) if (wrst2 === 1'b1) wd2_hit <= 1'b1;

	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task print_verdict;
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Write with both halves offered together, response code into rsp
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		b = 1'b0;
		@(posedge clk_sys);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!b)
		begin
			@(negedge clk_sys);
			ta = aw_v & awr;
			tw = w_v & wrd;
			b = bv;
			rsp = br;
			@(posedge clk_sys);
			if (ta)
				aw_v <= 1'b0;
			if (tw)
				w_v <= 1'b0;
		end
		b_r <= 1'b0;
		// Response must follow the taking of both halves
		chk(32'({b, aw_v, w_v}), 32'h4);
	endtask

	// Read, data into rdv and response code into rsp
	task rd(input logic [7:0] a);
		logic ta, v;
		v = 1'b0;
		@(posedge clk_sys);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		while (!v)
		begin
			@(negedge clk_sys);
			ta = ar_v & arr;
			v = rv;
			rdv = rdd;
			rsp = rr;
			@(posedge clk_sys);
			if (ta)
				ar_v <= 1'b0;
		end
		r_r <= 1'b0;
		// Read data must follow the taking of the address
		chk(32'({v, ar_v}), 32'h2);
	endtask

	// One-cycle core pulse {instr_end, stop, wait}; o gets {start, stop, wait} one cycle later
	task core(input logic [2:0] p);
		@(posedge clk_sys);
		{instr_end, stop_decoded, wait_decoded} <= p;
		@(posedge clk_sys);
		{instr_end, stop_decoded, wait_decoded} <= 3'h0;
		@(negedge clk_sys);
		o = {ist, est, ewt};
		o2 = {ist2, est2, ewt2};
	endtask

	// Hang guard
	initial
	begin
		#50000;
		err_count++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		{nrst, aw_v, w_v, b_r, ar_v, r_r, instr_end, int_mask_bit, stop_decoded, wait_decoded} = '0;
		{aw_a, ar_a, w_d} = '0;
		ext_int_n = 1'b1;
		keyscan_pin = 8'hFF;
		svc = 1'b1;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(option_cfg_pkg::OFS_OPTIONS);
		chk(rdv, 32'h0000050F);
		chk(32'({lvo, sto, wdo, kpe}), 32'h0000050F);
		chk(32'({lvo2, sto2, wdo2, kpe2}), 32'h000002F0);
		wr(option_cfg_pkg::OFS_OPTIONS, 32'h00000000);
		chk(32'(rsp), 32'(option_cfg_pkg::RESP_SLVERR));
		rd(option_cfg_pkg::OFS_OPTIONS);
		chk(rdv, 32'h0000050F);
		wr(8'h40, 32'h0000001F);
		chk(32'(rsp), 32'(option_cfg_pkg::RESP_SLVERR));
		rd(8'h40);
		chk({rdv[29:0], rsp}, 32'(option_cfg_pkg::RESP_SLVERR));
		rd(option_cfg_pkg::OFS_STATUS);
		chk(rdv, 32'h00000000);
		// Stop behaves as wait, and as true stop in the second build
		core(3'b010);
		chk(32'(o), 32'h1);
		chk(32'(o2), 32'h2);
		core(3'b001);
		chk(32'(o), 32'h1);
		chk(32'(o2), 32'h1);
		rd(option_cfg_pkg::OFS_STATUS);
		chk(rdv & 32'h00000018, 32'h00000010);
		// Watchdog period without service, then its interrupt
		@(posedge clk_sys);
		svc <= 1'b0;
		for (k = 0; k < 3 * WDG && wrst !== 1'b1; k++) @(negedge clk_sys);
		@(negedge clk_sys);
		for (k = 1; k < 3 * WDG && wrst !== 1'b1; k++) @(negedge clk_sys);
		chk(32'(k), 32'(WDG));
		chk(32'(wd2_hit), 32'h0);
		svc <= 1'b1;
		wr(option_cfg_pkg::OFS_MASK, 32'h00000004);
		@(negedge clk_sys);
		chk(32'(irq), 32'h1);
		wr(option_cfg_pkg::OFS_STATUS, 32'h0000001F);
		repeat (2) @(negedge clk_sys);
		chk(32'(irq), 32'h0);
		wr(option_cfg_pkg::OFS_MASK, 32'h00000000);
		// Held low pin: taken, re-set, masked, then released
		ext_int_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		core(3'b100);
		chk(32'(o[2]), 32'h1);
		chk(32'(o2[2]), 32'h1);
		core(3'b100);
		chk(32'(o[2]), 32'h1);
		chk(32'(o2[2]), 32'h0);
		@(posedge clk_sys);
		int_mask_bit <= 1'b1;
		core(3'b100);
		chk(32'(o[2]), 32'h0);
		@(posedge clk_sys);
		ext_int_n <= 1'b1;
		int_mask_bit <= 1'b0;
		repeat (8) @(posedge clk_sys);
		core(3'b100);
		chk(32'(o[2]), 32'h1);
		core(3'b100);
		chk(32'(o[2]), 32'h0);
		// Enabled keyscan line 0 against disabled line 7
		for (i = 0; i < 2; i++)
		begin
			wr(option_cfg_pkg::OFS_STATUS, 32'h0000001F);
			keyscan_pin <= (i == 0) ? 8'hFE : 8'h7F;
			repeat (8) @(posedge clk_sys);
			core(3'b100);
			chk(32'(o[2]), 32'(i == 0));
			chk(32'(o2[2]), 32'(i == 1));
			core(3'b100);
			chk(32'(o[2]), 32'(i == 0));
			chk(32'(o2[2]), 32'h0);
			@(posedge clk_sys);
			keyscan_pin <= 8'hFF;
			rd(option_cfg_pkg::OFS_STATUS);
			chk(32'(rdv[1]), 32'(i == 0));
			repeat (8) @(posedge clk_sys);
			core(3'b100);
		end
		print_verdict();
	end
endmodule // test_option_cfg
